// [rfs_pkg.sv]
// Package: register map, field positions and constants of the receive filter and status block
`default_nettype none
package rfs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W           = 8;
  localparam logic [7:0]  OFS_RX_CFG_STAT  = 8'h0c;  // Write: receive_config, read: receive_status
  localparam logic [7:0]  OFS_TX_PAGE      = 8'h10;  // transmit_page_start
  localparam logic [7:0]  OFS_TALLY_ALIGN  = 8'h14;  // alignment_tally
  localparam logic [7:0]  OFS_TALLY_CSUM   = 8'h18;  // checksum_error_tally
  localparam logic [7:0]  OFS_TALLY_MISSED = 8'h1c;  // missed_packet_tally

  // ----------------------------------------------------------------
  // receive_config fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_W            = 6;      // Bits 7:6 are not stored
  localparam int unsigned CFG_SAVE_ERR     = 0;
  localparam int unsigned CFG_ACCEPT_SHORT = 1;
  localparam int unsigned CFG_ACCEPT_BCAST = 2;
  localparam int unsigned CFG_ACCEPT_MCAST = 3;
  localparam int unsigned CFG_PROMISC      = 4;
  localparam int unsigned CFG_LISTEN_ONLY  = 5;
  localparam logic [5:0]  CFG_RESET        = 6'h00;

  // ----------------------------------------------------------------
  // receive_status fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_INTACT        = 0;
  localparam int unsigned ST_CSUM_ERR      = 1;
  localparam int unsigned ST_ALIGN_ERR     = 2;
  localparam int unsigned ST_OVERRUN       = 3;
  localparam int unsigned ST_MISSED        = 4;
  localparam int unsigned ST_ADDR_TYPE     = 5;
  localparam int unsigned ST_RX_DISABLED   = 6;
  localparam int unsigned ST_DEFERRING     = 7;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Packet length limits and misc
  // ----------------------------------------------------------------
  localparam logic [15:0] LEN_MIN_NORMAL   = 16'h0040; // 64 bytes
  localparam logic [15:0] LEN_MIN_SHORT    = 16'h0008; // 8 bytes
  localparam logic [2:0]  DRIBBLE_LIMIT    = 3'h6;     // Fewer dribble bits with good checksum: no error
  localparam int unsigned TALLY_W          = 8;
  localparam logic [7:0]  TALLY_MAX        = 8'hff;
  localparam logic [7:0]  PAGE_RESET       = 8'h00;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage
`default_nettype wire

// [rfs_rx_filter_status.sv]
// Receive filter, receive status, tally counters and transmit page start with an AXI4-Lite slave
// Contract
// - Save-errored bit set accepts checksum/alignment errored packets; clear rejects them.
// - Packets under 64 bytes rejected unless short-accept set; then need at least 8.
// - Broadcast destination accepted only with the accept-broadcast bit set.
// - Multicast accepted only with accept-multicast set and hash filter bit set.
// - Promiscuous bit accepts any physical address; else station address must match.
// - Listen-only checks packets, never buffers them, counts each recognized one without overrun as missed.
// - Broadcast and multicast acceptance OR together and add to own-address acceptance.
// - Status byte stored after good packet, at head if errored saved, never if rejected.
// - Receive status cleared when the next packet arrives.
// - Intact flag set only when checksum, alignment, overrun and missed flags are zero.
// - Checksum flag set on checksum or alignment error; checksum tally increments.
// - Alignment flag and tally on non-byte end with checksum failing.
// - Good checksum with under six dribble bits is no error; alignment-only never occurs.
// - FIFO overflow during reception sets overrun flag and aborts the packet.
// - Missed flag and tally when no buffer is available or in listen-only mode.
// - Address type flag: 0 physical match, 1 multicast or broadcast match.
// - Receiver-disabled flag follows entry to and exit from listen-only mode.
// - Deferring flag set by carrier sense or collision, held during jabber.
// - All registers are 8 bits wide; wider values split into byte halves.
// - Transmit start loads page into address bits 15-8, low byte zero.
// - Page registers hold and compare only address bits 15-8.
// - Offset 0x0c writes receive configuration and reads receive status.
// - Six latched checksum bits select one of 64 hash filter bits.
//
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
module rfs_rx_filter_status
  import rfs_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Receive engine events
  input  wire logic              rx_start_i,
  input  wire logic              rx_end_i,
  input  wire logic [15:0]       rx_length_i,
  input  wire logic [47:0]       rx_dest_addr_i,
  input  wire logic [5:0]        rx_hash_i,
  input  wire logic              rx_csum_ok_i,
  input  wire logic [2:0]        rx_dribble_i,
  input  wire logic              rx_fifo_overflow_i,
  input  wire logic              rx_no_buffer_i,
  input  wire logic [47:0]       station_addr_i,
  input  wire logic [63:0]       hash_filter_i,
  input  wire logic              carrier_sense_i,
  input  wire logic              collision_i,
  input  wire logic              tx_start_i,
  // Results
  output logic                   rx_accept_o,
  output logic                   rx_abort_o,
  output logic                   rx_buffer_en_o,
  output logic                   status_wr_o,
  output logic                   status_at_head_o,
  output logic [7:0]             status_byte_o,
  output logic [15:0]            tx_dma_addr_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CFG_W-1:0]   cfg;
    logic [7:0]         tx_page;
    logic [7:0]         status;
    logic [15:0]        dma_addr;
    logic [TALLY_W-1:0] tally_align;
    logic [TALLY_W-1:0] tally_csum;
    logic [TALLY_W-1:0] tally_missed;
    logic               in_packet;
    logic               overrun;
    logic               aw_have;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_have;
    logic [7:0]         w_data;
    logic               w_lane0;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [7:0]         rdata;
    logic [1:0]         rresp;
    logic               accept;
    logic               abort;
    logic               st_wr;
    logic               st_head;
  } rfs_state_s;

  rfs_state_s st_r;
  rfs_state_s st_nxt;

  // ----------------------------------------------------------------
  // Packet classification
  // ----------------------------------------------------------------
  logic is_bcast;
  logic is_mcast;
  logic phys_ok;
  logic mcast_ok;
  logic addr_ok;
  logic len_ok;
  logic misaligned;
  logic csum_err;
  logic align_err;
  logic errored;
  logic recognized;
  logic missed;
  logic overrun_now;
  logic accept_now;
  logic [7:0] final_status;

  // Destination class, filter and error decode
  always_comb begin
    is_bcast   = &rx_dest_addr_i;
    is_mcast   = rx_dest_addr_i[0] && !is_bcast;
    phys_ok    = st_r.cfg[CFG_PROMISC] || (rx_dest_addr_i == station_addr_i);
    mcast_ok   = st_r.cfg[CFG_ACCEPT_MCAST] && hash_filter_i[rx_hash_i];
    addr_ok    = is_bcast ? st_r.cfg[CFG_ACCEPT_BCAST] :
                 is_mcast ? mcast_ok : phys_ok;
    len_ok     = (rx_length_i >= LEN_MIN_NORMAL) ||
                 (st_r.cfg[CFG_ACCEPT_SHORT] && rx_length_i >= LEN_MIN_SHORT);
    misaligned = (rx_dribble_i != 3'h0);
    csum_err   = !rx_csum_ok_i;
    align_err  = misaligned && !rx_csum_ok_i;
    errored    = csum_err;
    recognized = addr_ok && len_ok;
    overrun_now = st_r.overrun || rx_fifo_overflow_i;
    missed     = recognized && !overrun_now &&
                 (st_r.cfg[CFG_LISTEN_ONLY] || rx_no_buffer_i);
    accept_now = recognized && !overrun_now && !missed &&
                 (!errored || st_r.cfg[CFG_SAVE_ERR]);
    final_status = st_r.status;
    final_status[ST_CSUM_ERR]  = csum_err;
    final_status[ST_ALIGN_ERR] = align_err;
    final_status[ST_OVERRUN]   = overrun_now;
    final_status[ST_MISSED]    = missed;
    final_status[ST_ADDR_TYPE] = is_bcast || is_mcast;
    final_status[ST_INTACT]    = !csum_err && !align_err && !overrun_now && !missed;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wr_fire;
  logic [7:0] rd_data;
  logic       rd_ok;

  always_comb begin
    st_nxt = st_r;
    st_nxt.accept = 1'b0;
    st_nxt.abort  = 1'b0;
    st_nxt.st_wr  = 1'b0;
    st_nxt.st_head = 1'b0;

    // Deferring flag is a live view of carrier sense and collision (held line during jabber)
    st_nxt.status[ST_DEFERRING] = carrier_sense_i || collision_i;

    // Packet start clears the status byte except the receiver-disabled and deferring bits
    if (rx_start_i) begin
      st_nxt.status = STATUS_RESET;
      st_nxt.status[ST_RX_DISABLED] = st_r.cfg[CFG_LISTEN_ONLY];
      st_nxt.status[ST_DEFERRING]   = carrier_sense_i || collision_i;
      st_nxt.in_packet = 1'b1;
      st_nxt.overrun   = 1'b0;
    end

    // FIFO overflow aborts the packet in flight
    if (st_r.in_packet && rx_fifo_overflow_i && !st_r.overrun) begin
      st_nxt.overrun = 1'b1;
      st_nxt.abort   = 1'b1;
      st_nxt.status[ST_OVERRUN] = 1'b1;
    end

    // Packet end: final status, tallies, status write to buffer memory
    if (rx_end_i && st_r.in_packet) begin
      st_nxt.in_packet = 1'b0;
      st_nxt.status[6:0] = final_status[6:0];
      st_nxt.accept = accept_now;
      st_nxt.st_wr  = accept_now;
      st_nxt.st_head = accept_now && errored;
      if (recognized && csum_err && st_r.tally_csum != TALLY_MAX) begin
        st_nxt.tally_csum = st_r.tally_csum + 8'h01;
      end
      if (recognized && align_err && st_r.tally_align != TALLY_MAX) begin
        st_nxt.tally_align = st_r.tally_align + 8'h01;
      end
      if (missed && st_r.tally_missed != TALLY_MAX) begin
        st_nxt.tally_missed = st_r.tally_missed + 8'h01;
      end
    end

    // Transmit start loads the page into the upper address byte
    if (tx_start_i) begin
      st_nxt.dma_addr = {st_r.tx_page, 8'h00};
    end

    // Write channel capture, address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_have  = 1'b1;
      st_nxt.w_data  = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      unique case ({st_r.aw_addr[ADDR_W-1:2], 2'b00})
        OFS_RX_CFG_STAT: begin
          if (st_r.w_lane0) begin
            st_nxt.cfg = st_r.w_data[CFG_W-1:0];
            st_nxt.status[ST_RX_DISABLED] = st_r.w_data[CFG_LISTEN_ONLY];
          end
        end
        OFS_TX_PAGE: begin
          if (st_r.w_lane0) begin
            st_nxt.tx_page = st_r.w_data;
          end
        end
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_data;
      st_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // Read decode, all registers 8 bits wide
  always_comb begin
    rd_data = 8'h00;
    rd_ok   = 1'b1;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      OFS_RX_CFG_STAT:  rd_data = st_r.status;
      OFS_TX_PAGE:      rd_data = st_r.tx_page;
      OFS_TALLY_ALIGN:  rd_data = st_r.tally_align;
      OFS_TALLY_CSUM:   rd_data = st_r.tally_csum;
      OFS_TALLY_MISSED: rd_data = st_r.tally_missed;
      default:          rd_ok   = 1'b0;
    endcase
  end

  // Handshakes
  assign wr_fire       = st_r.aw_have && st_r.w_have && !st_r.bvalid;
  assign s_axi_awready = !st_r.aw_have;
  assign s_axi_wready  = !st_r.w_have;
  assign s_axi_arready = !st_r.rvalid;

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.cfg      <= CFG_RESET;
      st_r.tx_page  <= PAGE_RESET;
      st_r.status   <= STATUS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign s_axi_bvalid     = st_r.bvalid;
  assign s_axi_bresp      = st_r.bresp;
  assign s_axi_rvalid     = st_r.rvalid;
  assign s_axi_rresp      = st_r.rresp;
  assign s_axi_rdata      = {24'h000000, st_r.rdata};
  assign rx_accept_o      = st_r.accept;
  assign rx_abort_o       = st_r.abort;
  assign rx_buffer_en_o   = !st_r.cfg[CFG_LISTEN_ONLY];
  assign status_wr_o      = st_r.st_wr;
  assign status_at_head_o = st_r.st_head;
  assign status_byte_o    = st_r.status;
  assign tx_dma_addr_o    = st_r.dma_addr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_pkt_end;
    rx_end_i && st_r.in_packet;
  endsequence

  chk_errored_reject: assert property (s_pkt_end ##0 (csum_err && !st_r.cfg[CFG_SAVE_ERR]) |=> !rx_accept_o)
    else $error("errored packet accepted while errors rejected");
  chk_short_reject: assert property (s_pkt_end ##0 (rx_length_i < LEN_MIN_SHORT) |=> !rx_accept_o)
    else $error("packet below minimum length accepted");
  chk_bcast_reject: assert property (s_pkt_end ##0 (is_bcast && !st_r.cfg[CFG_ACCEPT_BCAST]) |=> !rx_accept_o)
    else $error("broadcast accepted with broadcast disabled");
  chk_listen_no_store: assert property (s_pkt_end ##0 st_r.cfg[CFG_LISTEN_ONLY] |=> !status_wr_o && !rx_accept_o)
    else $error("packet stored in listen-only mode");
  chk_status_head: assert property (status_wr_o && status_byte_o[ST_CSUM_ERR] |-> status_at_head_o)
    else $error("errored status not marked for head");
  chk_start_clear: assert property (rx_start_i |=> status_byte_o[5:0] == 6'h00)
    else $error("status not cleared at packet start");
  chk_intact_flag: assert property (s_pkt_end |=> status_byte_o[ST_INTACT] == (status_byte_o[4:1] == 4'h0))
    else $error("intact flag disagrees with error flags");
  chk_align_legal: assert property (status_byte_o[ST_ALIGN_ERR] |-> status_byte_o[ST_CSUM_ERR])
    else $error("alignment error without checksum error");
  chk_overrun_abort: assert property (st_r.in_packet && rx_fifo_overflow_i && !st_r.overrun |=> rx_abort_o ##1 !rx_abort_o)
    else $error("overflow did not abort once");
  chk_tx_page_load: assert property (tx_start_i |=> tx_dma_addr_o == {$past(st_r.tx_page), 8'h00})
    else $error("transmit address not loaded from page");

endmodule
`default_nettype wire

// [rfs_buf_mem_model.sv]
// Buffer memory model that stores the receive status bytes written by the block
`default_nettype none
module rfs_buf_mem_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic       status_wr_i,
  input  wire logic [7:0] status_byte_i,
  output logic            no_buffer_o,
  output logic [7:0]      stored_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_r [16];
  // Out of buffers when the ring is full or the host holds it
  assign no_buffer_o = stall_i || (stored_o == 8'h10);
  // One byte-wide location per status write
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      stored_o <= 8'h00;
    end else if (status_wr_i && !no_buffer_o) begin
      mem_r[stored_o[3:0]] <= status_byte_i;
      stored_o <= stored_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [rfs_rx_filter_status_tb_top.sv]
// Self-checking testbench of the receive filter and status block
`default_nettype none
module rfs_rx_filter_status_tb_top;
  import rfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 0, rst_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, rx_start_i = 0, rx_end_i = 0, rx_csum_ok_i = 1;
  logic        rx_fifo_overflow_i = 0, carrier_sense_i = 0, collision_i = 0, tx_start_i = 0, stall = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, stored, pg;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 0;
  logic [15:0] rx_length_i = 0, tx_dma_addr_o;
  logic [47:0] rx_dest_addr_i = 0, station_addr_i = 0, oth;
  logic [5:0]  rx_hash_i = 0;
  logic [2:0]  rx_dribble_i = 0;
  logic [63:0] hash_filter_i = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_no_buffer_i;
  logic        rx_accept_o, rx_abort_o, rx_buffer_en_o, status_wr_o, status_at_head_o, end_d = 0;
  logic [7:0]  status_byte_o;
  logic [11:0] notes [$];
  logic [11:0] note;
  int          err_total = 0, tests_run = 0, cyc = 0, n_acc = 0, n_al = 0, n_crc = 0, n_mis = 0;

  rfs_rx_filter_status rfs_rx_filter_status_i (.clk_sys_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_start_i, .rx_end_i, .rx_length_i, .rx_dest_addr_i, .rx_hash_i,
    .rx_csum_ok_i, .rx_dribble_i, .rx_fifo_overflow_i, .rx_no_buffer_i, .station_addr_i, .hash_filter_i,
    .carrier_sense_i, .collision_i, .tx_start_i, .rx_accept_o, .rx_abort_o, .rx_buffer_en_o,
    .status_wr_o, .status_at_head_o, .status_byte_o, .tx_dma_addr_o);
  rfs_buf_mem_model rfs_buf_mem_model_i (.clk_sys_i, .rst_i, .stall_i(stall), .status_wr_i(status_wr_o),
    .status_byte_i(status_byte_o), .no_buffer_o(rx_no_buffer_i), .stored_o(stored));

  // Free-running system clock
  initial forever #4 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Expected filter outcome {compare, accept, write, head, status} from the current packet inputs
  function automatic logic [11:0] expect_of(input logic [7:0] cfg, input logic ov);
    logic bc, mc, rec, crc, al, mis, acc;
    bc = &rx_dest_addr_i;
    mc = rx_dest_addr_i[0] && !bc;
    rec = (bc ? cfg[2] : mc ? cfg[3] && hash_filter_i[rx_hash_i] : cfg[4] || rx_dest_addr_i == station_addr_i)
          && (rx_length_i >= LEN_MIN_NORMAL || (cfg[1] && rx_length_i >= LEN_MIN_SHORT));
    crc = !rx_csum_ok_i;
    al = crc && rx_dribble_i != 3'h0;
    mis = rec && !ov && (cfg[5] || rx_no_buffer_i);
    acc = rec && !ov && !mis && (!crc || cfg[0]);
    if (rec) begin
      n_crc += int'(crc);
      n_al += int'(al);
      n_mis += int'(mis);
      n_acc += int'(acc);
    end
    return {rec && !ov, acc, acc, acc && crc, 1'b0, cfg[5], bc || mc, mis, ov, al, crc, !(crc || ov || mis)};
  endfunction

  // Marks the cycle whose outputs answer a packet end
  always @(posedge clk_sys_i) end_d <= rx_end_i;

  // Takes the oldest note when a packet result is due
  always @(negedge clk_sys_i) begin
    if (end_d) begin
      note = notes.pop_front();
      chk(16'({rx_accept_o, status_wr_o, status_at_head_o}), 16'(note[10:8]));
      if (note[11]) chk(16'(status_byte_o), 16'(note[7:0]));
    end
  end

  // Cuts a hang short
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and packet drivers
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic da, dw, ha, hw, hb;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    da = 0;
    dw = 0;
    hb = 0;
    while (!(da && dw)) begin
      @(negedge clk_sys_i);
      ha = s_axi_awready && !da;
      hw = s_axi_wready && !dw;
      @(posedge clk_sys_i);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      da |= ha;
      dw |= hw;
    end
    while (!hb) begin
      @(negedge clk_sys_i);
      hb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk_sys_i);
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic h;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    h = 0;
    while (!h) begin
      @(negedge clk_sys_i);
      h = s_axi_arready;
      @(posedge clk_sys_i);
    end
    s_axi_arvalid <= 1'b0;
    h = 0;
    while (!h) begin
      @(negedge clk_sys_i);
      h = s_axi_rvalid;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys_i);
    end
    s_axi_rready <= 1'b0;
  endtask

  // One packet: start, optional overflow, end; a zero length asks for a random legal one
  task automatic pkt(input logic [7:0] cfg, input logic [47:0] da, input logic [15:0] ln,
                     input logic [5:0] h, input logic [3:0] ok_dr, input logic nb, input logic ov);
    axi_wr(OFS_RX_CFG_STAT, cfg);
    @(posedge clk_sys_i);
    rx_start_i <= 1'b1;
    rx_dest_addr_i <= da;
    rx_length_i <= (ln != 16'h0) ? ln : LEN_MIN_NORMAL + 16'($urandom_range(1400));
    rx_hash_i <= h;
    {rx_csum_ok_i, rx_dribble_i} <= ok_dr;
    stall <= nb;
    @(posedge clk_sys_i);
    rx_start_i <= 1'b0;
    rx_fifo_overflow_i <= ov;
    @(negedge clk_sys_i);
    chk(16'(status_byte_o[5:0]), 16'h0);
    @(posedge clk_sys_i);
    rx_fifo_overflow_i <= 1'b0;
    @(negedge clk_sys_i);
    if (ov) chk(16'(rx_abort_o), 16'h1);
    chk(16'(rx_buffer_en_o), 16'(!cfg[5]));
    @(posedge clk_sys_i);
    rx_end_i <= 1'b1;
    notes.push_back(expect_of(cfg, ov));
    @(posedge clk_sys_i);
    rx_end_i <= 1'b0;
    stall <= 1'b0;
    @(negedge clk_sys_i);
    if (ov) chk(16'(status_byte_o[3]), 16'h1);
    repeat (2) @(posedge clk_sys_i);
  endtask

  // Main sequence
  initial begin
    void'($urandom(91422));
    station_addr_i <= 48'({$urandom(), $urandom()}) & 48'hffff_ffff_fffe;
    hash_filter_i <= ({$urandom(), $urandom()} | 64'h20) & ~64'h200;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    oth = station_addr_i ^ 48'h0000_0000_0100;
    axi_wr(OFS_RX_CFG_STAT, 8'he0);
    chk(16'(resp), 16'(RESP_OKAY));
    axi_rd(OFS_RX_CFG_STAT);
    chk(16'(rd_data[7:6]), 16'h1);
    axi_wr(OFS_RX_CFG_STAT, 8'hc0);
    axi_rd(OFS_RX_CFG_STAT);
    chk(16'(rd_data[6]), 16'h0);
    axi_rd(8'h40);
    chk(16'(resp), 16'(RESP_SLVERR));
    axi_wr(OFS_TALLY_ALIGN, 8'h55);
    chk(16'(resp), 16'(RESP_SLVERR));
    pg = 8'($urandom());
    axi_wr(OFS_TX_PAGE, pg);
    @(posedge clk_sys_i) tx_start_i <= 1'b1;
    @(posedge clk_sys_i) tx_start_i <= 1'b0;
    @(negedge clk_sys_i) chk(tx_dma_addr_o, {pg, 8'h00});
    axi_rd(OFS_TX_PAGE);
    chk(16'(rd_data), 16'(pg));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) {collision_i, carrier_sense_i} <= 2'(i);
      axi_rd(OFS_RX_CFG_STAT);
      chk(16'(rd_data[7]), 16'(i != 0));
    end
    // Quiet medium again, so the deferring bit reads zero in every packet status below
    @(posedge clk_sys_i) {collision_i, carrier_sense_i} <= 2'b00;
    pkt(8'h00, station_addr_i, 16'h0, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h00, oth, 16'h0, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h10, oth, 16'h0, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h00, '1, 16'h0, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h04, '1, 16'h0, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h08, 48'h1234_5678_9ab1, 16'h0, 6'd5, 4'h8, 1'b0, 1'b0);
    pkt(8'h08, 48'h1234_5678_9ab1, 16'h0, 6'd9, 4'h8, 1'b0, 1'b0);
    pkt(8'h04, 48'h1234_5678_9ab1, 16'h0, 6'd5, 4'h8, 1'b0, 1'b0);
    pkt(8'h0c, '1, 16'h0, 6'd9, 4'h8, 1'b0, 1'b0);
    pkt(8'h00, station_addr_i, 16'd63, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h02, station_addr_i, 16'd8, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h02, station_addr_i, 16'd7, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h00, station_addr_i, 16'h0, 6'd0, 4'h3, 1'b0, 1'b0);
    pkt(8'h01, station_addr_i, 16'h0, 6'd0, 4'h0, 1'b0, 1'b0);
    pkt(8'h01, station_addr_i, 16'h0, 6'd0, 4'h3, 1'b0, 1'b0);
    pkt(8'h00, station_addr_i, 16'h0, 6'd0, 4'hd, 1'b0, 1'b0);
    pkt(8'h00, station_addr_i, 16'h0, 6'd0, 4'h8, 1'b1, 1'b0);
    pkt(8'h20, station_addr_i, 16'h0, 6'd0, 4'h8, 1'b0, 1'b0);
    pkt(8'h00, station_addr_i, 16'h0, 6'd0, 4'h8, 1'b0, 1'b1);
    axi_rd(OFS_TALLY_ALIGN);
    chk(16'(rd_data), 16'(n_al));
    axi_rd(OFS_TALLY_CSUM);
    chk(16'(rd_data), 16'(n_crc));
    axi_rd(OFS_TALLY_MISSED);
    chk(16'(rd_data), 16'(n_mis));
    chk(16'(stored), 16'(n_acc));
    end_of_test();
  end
endmodule
`default_nettype wire
